// file: inc/tws_pkg.sv
// Shared constants and types for the two-wire slave block.
package tws_pkg;
  localparam logic [7:0] OFS_OWN   = 8'h00;
  localparam logic [7:0] OFS_CTRL  = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_DATA  = 8'h0C;
  localparam int         C_INT     = 7;
  localparam int         C_ACK     = 6;
  localparam int         C_STA     = 5;
  localparam int         C_STO     = 4;
  localparam int         C_WC      = 3;
  localparam int         C_EN      = 2;
  localparam int         C_IE      = 0;
  localparam int         OWN_GC    = 0;
  localparam logic [7:0] OWN_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'hFF;
  localparam logic [7:0] SH_RST    = 8'hFF;
  localparam logic [1:0] PRE_RST   = 2'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] ST_60     = 8'h60;
  localparam logic [7:0] ST_68     = 8'h68;
  localparam logic [7:0] ST_70     = 8'h70;
  localparam logic [7:0] ST_78     = 8'h78;
  localparam logic [7:0] ST_80     = 8'h80;
  localparam logic [7:0] ST_88     = 8'h88;
  localparam logic [7:0] ST_90     = 8'h90;
  localparam logic [7:0] ST_98     = 8'h98;
  localparam logic [7:0] ST_A0     = 8'hA0;
  localparam logic [7:0] ST_A8     = 8'hA8;
  localparam logic [7:0] ST_B0     = 8'hB0;
  localparam logic [7:0] ST_B8     = 8'hB8;
  localparam logic [7:0] ST_C0     = 8'hC0;
  localparam logic [7:0] ST_C8     = 8'hC8;
  localparam logic [7:0] ST_F8     = 8'hF8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLV  = 2'h2;
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_ADDR = 7'h02,
    S_AACK = 7'h04,
    S_RX   = 7'h08,
    S_RACK = 7'h10,
    S_TX   = 7'h20,
    S_TACK = 7'h40
  } tws_state_type;
endpackage : tws_pkg

// file: inc/tws_cond_if.sv
// Bus conditions passed from the line detector to the slave engine.
`timescale 1ns/100ps
interface tws_cond_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic busy;
  modport det (output scl, sda, scl_rise, scl_fall, start, stop, busy);
  modport eng (input scl, sda, scl_rise, scl_fall, start, stop, busy);
endinterface : tws_cond_if

// file: hdl/tws_cond_det.sv
// Line synchroniser and START, STOP and clock edge detector.
`timescale 1ns/100ps
module tws_cond_det
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic scl_in,
  input  wire logic sda_in,
  tws_cond_if.det   cnd
);
  logic scl_s1_ff, scl_s2_ff, scl_d_ff;
  logic sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic busy_ff;
  logic nxt_busy;

  always_comb
  begin
    cnd.scl      = scl_s2_ff;
    cnd.sda      = sda_s2_ff;
    cnd.scl_rise = scl_s2_ff && !scl_d_ff;
    cnd.scl_fall = !scl_s2_ff && scl_d_ff;
    cnd.start    = scl_s2_ff && scl_d_ff && sda_d_ff && !sda_s2_ff;
    cnd.stop     = scl_s2_ff && scl_d_ff && !sda_d_ff && sda_s2_ff;
    cnd.busy     = busy_ff;
    nxt_busy     = busy_ff;
    if (cnd.start)
      nxt_busy = 1'b1;
    else if (cnd.stop)
      nxt_busy = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff  <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff  <= 1'b1;
      busy_ff   <= 1'b0;
    end
    else
    begin
      scl_s1_ff <= scl_in;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff  <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff  <= sda_s2_ff;
      busy_ff   <= nxt_busy;
    end
  end
endmodule : tws_cond_det

// file: hdl/tws_slave_top.sv
// Two-wire slave engine with AXI4-Lite register access.
// Behaviour
// RL1 - General-call byte acked gives 0x90; next byte acked only if ack_enable.
// RL2 - General-call byte not acked gives 0x98; slave becomes not addressed.
// RL3 - STOP or repeated START while addressed gives 0xA0 and not addressed; code gives 0xA0 only from S_RX or S_RACK, other states just drop the address.
// RL4 - Leaving terminal state with start_request queues START until bus free.
// RL5 - Status code read with prescaler bits zero or masked off.
// RL6 - Own address in upper seven bits; bit zero enables general call.
// RL7 - Software arms with interface_enable and ack_enable set, requests clear.
// RL8 - Matched address with read bit enters transmit, else receive.
// RL9 - After address acknowledge, flag is set and status valid.
// RL10 - Lost arbitration then addressed for read gives 0xB0 and transmits.
// RL11 - Last byte sent gives 0xC0 on NACK, 0xC8 on ACK.
// RL12 - After last byte, slave releases data so master reads ones.
// RL13 - With ack_enable clear, own address is ignored but bus still watched.
// RL14 - In clock-stopped sleep, address matching and acknowledge still work.
// RL15 - Sleep match wakes device and holds clock low until flag cleared.
// RL16 - Data register may miss the last bus byte after sleep wake.
// RL17 - Own address read acked gives 0xA8, then loaded byte is sent.
// RL18 - Transmitted byte acked by master gives 0xB8, next byte sent.
// RL19 - With flag clear, status reads 0xF8.
// RL20 - While flag set in a slave state, clock is held low.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module tws_slave_top
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic        SLEEP_IN,
  output logic             WAKE_REQ,
  input  wire logic        ARB_LOST,
  output logic             START_ISSUE
);
  import tws_pkg::*;

  tws_cond_if cnd ();

  tws_cond_det u_det
  (
    .clk     (CLK),
    .reset_n (RESET_N),
    .scl_in  (SCL_IN),
    .sda_in  (SDA_IN),
    .cnd     (cnd.det)
  );

  tws_state_type state_ff, nxt_state;
  logic          aw_ff, nxt_aw, w_ff, nxt_w, bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
  logic [7:0]    awaddr_ff, nxt_awaddr, wdata_ff, nxt_wdata;
  logic          wstrb_ff, nxt_wstrb;
  logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [7:0]    rdata_ff, nxt_rdata;
  logic [7:0]    own_ff, nxt_own, ctrl_ff, nxt_ctrl, data_ff, nxt_data, code_ff, nxt_code;
  logic [1:0]    pre_ff, nxt_pre;
  logic [7:0]    sh_ff, nxt_sh;
  logic [3:0]    cnt_ff, nxt_cnt;
  logic          rd_ff, nxt_rd, gc_ff, nxt_gc, ackq_ff, nxt_ackq, last_ff, nxt_last;
  logic          mack_ff, nxt_mack, arb_ff, nxt_arb, pend_ff, nxt_pend, issue_ff, nxt_issue;
  logic          sleep_s1_ff, sleep_s2_ff;
  logic          scl_oe_n_ff, nxt_scl_oe_n, sda_oe_n_ff, nxt_sda_oe_n;
  logic          do_wr, clr, set, addressed, nxt_addressed, own_hit, gc_hit;
  logic [7:0]    stat_view;

  assign AWREADY     = !aw_ff && !bvalid_ff;
  assign WREADY      = !w_ff && !bvalid_ff;
  assign ARREADY     = !rvalid_ff;
  assign BVALID      = bvalid_ff;
  assign BRESP       = bresp_ff;
  assign RVALID      = rvalid_ff;
  assign RRESP       = rresp_ff;
  assign RDATA       = {24'h000000, rdata_ff};
  assign SCL_OUT     = 1'b0;
  assign SDA_OUT     = 1'b0;
  assign SCL_OE_N    = scl_oe_n_ff;
  assign SDA_OE_N    = sda_oe_n_ff;
  assign START_ISSUE = issue_ff;
  assign WAKE_REQ    = sleep_s2_ff && ctrl_ff[C_INT];
  assign do_wr       = aw_ff && w_ff && !bvalid_ff;
  assign addressed   = state_ff inside {S_AACK, S_RX, S_RACK, S_TX, S_TACK};
  assign own_hit     = sh_ff[7:1] == own_ff[7:1];
  // The general call only counts when enabled and with the write direction.
  assign gc_hit      = sh_ff[7:1] == 7'h00 && own_ff[OWN_GC] && !sh_ff[0]; // [RL6]
  assign stat_view   = ctrl_ff[C_INT] ? {code_ff[7:2], pre_ff} : {ST_F8[7:2], pre_ff}; // [RL19] [RL5]

  always_comb
  begin
    nxt_aw = aw_ff; nxt_w = w_ff; nxt_awaddr = awaddr_ff; nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff; nxt_bvalid = bvalid_ff; nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff; nxt_rresp = rresp_ff; nxt_rdata = rdata_ff;
    nxt_own = own_ff; nxt_ctrl = ctrl_ff; nxt_data = data_ff; nxt_code = code_ff;
    nxt_pre = pre_ff; nxt_state = state_ff; nxt_sh = sh_ff; nxt_cnt = cnt_ff;
    nxt_rd = rd_ff; nxt_gc = gc_ff; nxt_ackq = ackq_ff; nxt_last = last_ff;
    nxt_mack = mack_ff; nxt_arb = arb_ff || ARB_LOST; nxt_pend = pend_ff;
    nxt_issue = 1'b0;
    clr = 1'b0;
    set = 1'b0;
    if (AWVALID && AWREADY)
    begin
      nxt_aw = 1'b1;
      nxt_awaddr = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      nxt_w = 1'b1;
      nxt_wdata = WDATA[7:0];
      nxt_wstrb = WSTRB[0];
    end
    if (BVALID && BREADY)
      nxt_bvalid = 1'b0;
    if (RVALID && RREADY)
      nxt_rvalid = 1'b0;
    if (do_wr)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OKAY;
      case (awaddr_ff)
        OFS_OWN:
          if (wstrb_ff)
            nxt_own = wdata_ff;
        OFS_CTRL:
          if (wstrb_ff)
          begin
            clr = wdata_ff[C_INT];
            nxt_ctrl = {ctrl_ff[C_INT] && !wdata_ff[C_INT], wdata_ff[6:4], ctrl_ff[C_WC], wdata_ff[2:0]};
          end
        OFS_STAT:
          if (wstrb_ff)
            nxt_pre = wdata_ff[1:0];
        OFS_DATA:
          if (wstrb_ff && ctrl_ff[C_INT])
          begin
            nxt_data = wdata_ff;
            nxt_ctrl[C_WC] = 1'b0;
          end
          else if (wstrb_ff)
            nxt_ctrl[C_WC] = 1'b1;
        default:
          nxt_bresp = RESP_SLV;
      endcase
    end
    if (ARVALID && ARREADY)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OKAY;
      case (ARADDR)
        OFS_OWN:  nxt_rdata = own_ff;
        OFS_CTRL: nxt_rdata = ctrl_ff;
        OFS_STAT: nxt_rdata = stat_view;
        OFS_DATA: nxt_rdata = data_ff;
        default:
        begin
          nxt_rdata = 8'h00;
          nxt_rresp = RESP_SLV;
        end
      endcase
    end
    // Software release of the flag: reload the transmitter or leave a terminal state.
    if (clr && ctrl_ff[C_INT])
    begin
      if (state_ff == S_TX)
      begin
        nxt_sh = data_ff;
        nxt_cnt = 4'h0;
        nxt_last = !nxt_ctrl[C_ACK]; // [RL17] [RL18]
      end
      if (nxt_ctrl[C_STO])
      begin
        nxt_state = S_IDLE;
        nxt_ctrl[C_STO] = 1'b0;
      end
      else if (state_ff == S_IDLE && nxt_ctrl[C_STA])
        nxt_pend = 1'b1; // [RL4]
    end
    if (pend_ff && !cnd.busy)
    begin
      nxt_pend = 1'b0;
      nxt_issue = 1'b1; // [RL4]
      nxt_ctrl[C_STA] = 1'b0;
    end
    // The engine works on the system clock whether or not the core sleeps. [RL14]
    if (!ctrl_ff[C_EN])
      nxt_state = S_IDLE;
    else if (cnd.start || cnd.stop)
    begin
      if (state_ff inside {S_RX, S_RACK})
      begin
        set = 1'b1;
        nxt_code = ST_A0; // [RL3]
      end
      nxt_state = cnd.start ? S_ADDR : S_IDLE;
      nxt_cnt = 4'h0;
    end
    else
    begin
      case (state_ff)
        S_ADDR, S_RX:
          if (cnd.scl_rise)
          begin
            nxt_sh = {sh_ff[6:0], cnd.sda};
            nxt_cnt = cnt_ff + 4'h1;
          end
          else if (cnd.scl_fall && cnt_ff == BYTE_BITS)
          begin
            nxt_cnt = 4'h0;
            if (state_ff == S_RX)
            begin
              nxt_ackq = ctrl_ff[C_ACK]; // [RL1]
              nxt_state = S_RACK;
            end
            else if (ctrl_ff[C_ACK] && (own_hit || gc_hit)) // [RL13] [RL6] [RL8]
            begin
              nxt_rd = sh_ff[0];
              nxt_gc = !own_hit;
              nxt_state = S_AACK;
            end
            else
              nxt_state = S_IDLE;
          end
        S_AACK:
          if (cnd.scl_fall)
          begin
            set = 1'b1; // [RL9]
            nxt_arb = 1'b0;
            nxt_state = rd_ff ? S_TX : S_RX; // [RL8]
            nxt_sh = data_ff;
            nxt_last = !ctrl_ff[C_ACK];
            if (rd_ff)
              nxt_code = arb_ff ? ST_B0 : ST_A8; // [RL10] [RL17]
            else if (gc_ff)
              nxt_code = arb_ff ? ST_78 : ST_70;
            else
              nxt_code = arb_ff ? ST_68 : ST_60;
          end
        S_RACK:
          if (cnd.scl_fall)
          begin
            set = 1'b1;
            // Asleep, the byte is not kept in the data register. [RL16]
            if (!sleep_s2_ff)
              nxt_data = sh_ff;
            nxt_state = ackq_ff ? S_RX : S_IDLE; // [RL2]
            if (gc_ff)
              nxt_code = ackq_ff ? ST_90 : ST_98; // [RL1] [RL2]
            else
              nxt_code = ackq_ff ? ST_80 : ST_88;
          end
        S_TX:
          if (cnd.scl_fall)
          begin
            nxt_sh = {sh_ff[6:0], 1'b1};
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == BYTE_BITS - 4'h1)
              nxt_state = S_TACK;
          end
        S_TACK:
          if (cnd.scl_rise)
            nxt_mack = !cnd.sda;
          else if (cnd.scl_fall)
          begin
            set = 1'b1;
            nxt_cnt = 4'h0;
            if (last_ff)
            begin
              nxt_code = mack_ff ? ST_C8 : ST_C0; // [RL11]
              nxt_state = S_IDLE; // [RL12]
            end
            else
            begin
              nxt_code = mack_ff ? ST_B8 : ST_C0; // [RL18]
              nxt_state = mack_ff ? S_TX : S_IDLE;
            end
          end
        default:
          nxt_cnt = 4'h0;
      endcase
    end
    // A hardware set in the same cycle as a software clear wins.
    if (set)
      nxt_ctrl[C_INT] = 1'b1;
    nxt_addressed = nxt_state inside {S_AACK, S_RX, S_RACK, S_TX, S_TACK};
    nxt_scl_oe_n = !(nxt_ctrl[C_INT] && nxt_addressed); // [RL20] [RL15]
    nxt_sda_oe_n = !(nxt_state == S_AACK || (nxt_state == S_RACK && nxt_ackq)
                    || (nxt_state == S_TX && !nxt_sh[7])); // [RL12]
  end

  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      aw_ff <= 1'b0; w_ff <= 1'b0; awaddr_ff <= 8'h00; wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0; bvalid_ff <= 1'b0; bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0; rresp_ff <= RESP_OKAY; rdata_ff <= 8'h00;
      own_ff <= OWN_RST; ctrl_ff <= CTRL_RST; data_ff <= DATA_RST;
      code_ff <= ST_F8; pre_ff <= PRE_RST; state_ff <= S_IDLE;
      sh_ff <= SH_RST; cnt_ff <= 4'h0; rd_ff <= 1'b0; gc_ff <= 1'b0;
      ackq_ff <= 1'b0; last_ff <= 1'b0; mack_ff <= 1'b0; arb_ff <= 1'b0;
      pend_ff <= 1'b0; issue_ff <= 1'b0;
      sleep_s1_ff <= 1'b0; sleep_s2_ff <= 1'b0;
      scl_oe_n_ff <= 1'b1; sda_oe_n_ff <= 1'b1;
    end
    else
    begin
      aw_ff <= nxt_aw; w_ff <= nxt_w; awaddr_ff <= nxt_awaddr; wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb; bvalid_ff <= nxt_bvalid; bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid; rresp_ff <= nxt_rresp; rdata_ff <= nxt_rdata;
      own_ff <= nxt_own; ctrl_ff <= nxt_ctrl; data_ff <= nxt_data;
      code_ff <= nxt_code; pre_ff <= nxt_pre; state_ff <= nxt_state;
      sh_ff <= nxt_sh; cnt_ff <= nxt_cnt; rd_ff <= nxt_rd; gc_ff <= nxt_gc;
      ackq_ff <= nxt_ackq; last_ff <= nxt_last; mack_ff <= nxt_mack; arb_ff <= nxt_arb;
      pend_ff <= nxt_pend; issue_ff <= nxt_issue;
      sleep_s1_ff <= SLEEP_IN; sleep_s2_ff <= sleep_s1_ff;
      scl_oe_n_ff <= nxt_scl_oe_n; sda_oe_n_ff <= nxt_sda_oe_n;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  property p_no_flag_f8;
    ARVALID && ARREADY && ARADDR == OFS_STAT && !ctrl_ff[C_INT] |=> RVALID && RDATA[7:2] == ST_F8[7:2];
  endproperty
  a_no_flag_f8: assert property (p_no_flag_f8) else $error("Status not F8 with flag clear."); // [RL19]

  property p_stretch;
    ctrl_ff[C_INT] && addressed |-> !SCL_OE_N;
  endproperty
  a_stretch: assert property (p_stretch) else $error("Clock not held while flag set."); // [RL20]

  property p_addr_flag;
    state_ff == S_AACK && cnd.scl_fall && ctrl_ff[C_EN] && !cnd.start && !cnd.stop
      |=> ctrl_ff[C_INT] && (state_ff == (rd_ff ? S_TX : S_RX));
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("No flag after address."); // [RL9]

  property p_read_code;
    state_ff == S_AACK && cnd.scl_fall && rd_ff && ctrl_ff[C_EN] && !cnd.start && !cnd.stop
      |=> code_ff == ($past(arb_ff) ? ST_B0 : ST_A8);
  endproperty
  a_read_code: assert property (p_read_code) else $error("Wrong read address code."); // [RL17]

  property p_last_byte;
    state_ff == S_TACK && cnd.scl_fall && last_ff && ctrl_ff[C_EN] && !cnd.start && !cnd.stop
      |=> code_ff == ($past(mack_ff) ? ST_C8 : ST_C0) ##1 state_ff == S_IDLE && SDA_OE_N;
  endproperty
  a_last_byte: assert property (p_last_byte) else $error("Last byte handling wrong."); // [RL11]

  property p_no_ack_addr;
    state_ff == S_ADDR && cnd.scl_fall && cnt_ff == BYTE_BITS && !ctrl_ff[C_ACK]
      && ctrl_ff[C_EN] && !cnd.start && !cnd.stop |=> state_ff == S_IDLE [*2];
  endproperty
  a_no_ack_addr: assert property (p_no_ack_addr) else $error("Answered with ack disabled."); // [RL13]

  property p_gc_byte;
    state_ff == S_RACK && cnd.scl_fall && gc_ff && ctrl_ff[C_EN] && !cnd.start && !cnd.stop
      |=> code_ff == ($past(ackq_ff) ? ST_90 : ST_98) && state_ff == ($past(ackq_ff) ? S_RX : S_IDLE);
  endproperty
  a_gc_byte: assert property (p_gc_byte) else $error("General call byte code wrong."); // [RL1]

  property p_stop_a0;
    state_ff inside {S_RX, S_RACK} && ctrl_ff[C_EN] && (cnd.stop || cnd.start)
      |=> code_ff == ST_A0 && ctrl_ff[C_INT] && !addressed;
  endproperty
  a_stop_a0: assert property (p_stop_a0) else $error("Missing A0 on STOP."); // [RL3]

  property p_start_issue;
    pend_ff && !cnd.busy |=> START_ISSUE ##1 !START_ISSUE && !pend_ff;
  endproperty
  a_start_issue: assert property (p_start_issue) else $error("Queued START not issued."); // [RL4]

  property p_sleep_data;
    state_ff == S_RACK && cnd.scl_fall && sleep_s2_ff && !do_wr |=> $stable(data_ff);
  endproperty
  a_sleep_data: assert property (p_sleep_data) else $error("Data stored while asleep."); // [RL16]

  c_tx_more: cover property (state_ff == S_TACK && cnd.scl_fall ##1 code_ff == ST_B8);
  c_gc_rx: cover property (code_ff == ST_90 && ctrl_ff[C_INT]);
  c_stop_a0: cover property (code_ff == ST_A0 && ctrl_ff[C_INT]);
  c_wake: cover property (WAKE_REQ ##1 !WAKE_REQ);
endmodule : tws_slave_top

// file: dv/tws_mstr.sv
// Behavioural two-wire bus master that clocks the slave and waits out clock stretching.
`timescale 1ns/100ps
module tws_mstr
(
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  output wire logic scl,
  output wire logic sda
);
  logic m_scl = 1'h1;
  logic m_sda = 1'h1;
  // Both lines have pull-ups, so a released line reads high and any low driver wins.
  assign scl = m_scl & scl_oe_n;
  assign sda = m_sda & sda_oe_n;
  // Data changes only while the clock is low and is sampled at the end of the high phase.
  task automatic bit_clk(input logic b, output logic r);
    #20 m_sda = b;
    #60 m_scl = 1'h1;
    wait (scl === 1'h1);
    #80 r = sda;
    m_scl = 1'h0;
  endtask : bit_clk
  // A zero makes a START (or repeated START), a one makes a STOP.
  task automatic line_cond(input logic s);
    #20 m_sda = !s;
    #60 m_scl = 1'h1;
    wait (scl === 1'h1);
    #80 m_sda = s;
    #80 m_scl = s;
  endtask : line_cond
  task automatic xfer(input logic [7:0] v, input logic ak, output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_clk(v[i], rd[i]);
    bit_clk(ak, ack);
  endtask : xfer
endmodule : tws_mstr

// file: dv/tb.sv
// Self-checking bench: register software and a two-wire master against the slave.
`timescale 1ns/100ps
module tb;
  import tws_pkg::*;
  logic        CLK = 1'h0, RESET_N = 1'h0, AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic        ARVALID = 1'h0, RREADY = 1'h0, SLEEP_IN = 1'h0, ARB_LOST = 1'h0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  WSTRB = 4'h1;
  logic [1:0]  BRESP, RRESP;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, SCL_OUT, SDA_OUT, SCL_OE_N, SDA_OE_N, WAKE_REQ;
  logic        START_ISSUE;
  wire         SCL_IN, SDA_IN;
  logic [31:0] seed = 32'h1D22E068;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, si_cnt = 0;
  logic [7:0]  q, d;
  logic [6:0]  own;
  logic        a;
  logic [7:0]  tx_q[$];
  tws_slave_top u_dut
  (
    .CLK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SCL_IN, .SCL_OUT, .SCL_OE_N, .SDA_IN,
    .SDA_OUT, .SDA_OE_N, .SLEEP_IN, .WAKE_REQ, .ARB_LOST, .START_ISSUE
  );
  tws_mstr u_mst (.scl_oe_n(SCL_OE_N), .sda_oe_n(SDA_OE_N), .scl(SCL_IN), .sda(SDA_IN));
  initial forever #4 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    si_cnt <= si_cnt + int'(START_ISSUE === 1'h1);
    if (cyc == 60000)
    begin
      error_cnt++;
      $display("BAD t=%0t timeout", $time);
      conclude();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    error_cnt += int'(s !== e);
    if (s !== e)
      $display("BAD t=%0t saw %h expected %h", $time, s, e);
  endtask : chk
  // Handshakes are judged on settled values half a cycle before the edge that takes them.
  task automatic axw(input logic [7:0] ad, input logic [7:0] v, input logic [1:0] er = RESP_OKAY,
                     input logic [3:0] sb = 4'h1);
    logic       ha;
    logic       hw;
    logic       hb;
    logic [1:0] rs;
    @(posedge CLK);
    {AWADDR, AWVALID, WVALID, BREADY, WSTRB} <= {ad, 3'h7, sb};
    WDATA <= {rnd(), rnd(), rnd(), v};
    do
    begin
      @(negedge CLK);
      ha = AWVALID && AWREADY;
      hw = WVALID && WREADY;
      hb = BVALID && BREADY;
      rs = BRESP;
      @(posedge CLK);
      if (ha)
        AWVALID <= 1'h0;
      if (hw)
        WVALID <= 1'h0;
    end while (!hb);
    BREADY <= 1'h0;
    chk(8'(rs), 8'(er));
  endtask : axw
  task automatic axr(input logic [7:0] ad, input logic [1:0] er = RESP_OKAY);
    logic       ha;
    logic       hr;
    logic [1:0] rs;
    @(posedge CLK);
    {ARADDR, ARVALID, RREADY} <= {ad, 2'h3};
    do
    begin
      @(negedge CLK);
      ha = ARVALID && ARREADY;
      hr = RVALID && RREADY;
      rs = RRESP;
      q = RDATA[7:0];
      @(posedge CLK);
      if (ha)
        ARVALID <= 1'h0;
    end while (!hr);
    RREADY <= 1'h0;
    chk(8'(rs), 8'(er));
  endtask : axr
  // Status is read with the prescaler bits masked off.
  task automatic sts(input logic [7:0] e);
    repeat (8) @(posedge CLK);
    axr(OFS_STAT);
    chk(q & 8'hF8, e);
  endtask : sts
  // The model keeps every byte software loads, in order of transmission.
  task automatic ld(input logic [7:0] c);
    d = rnd();
    tx_q.push_back(d);
    axw(OFS_DATA, d);
    axw(OFS_CTRL, c);
  endtask : ld
  task automatic rdb(input logic ak);
    u_mst.xfer(8'hFF, ak, q, a);
    chk(q, tx_q.pop_front());
  endtask : rdb
  task automatic adr(input logic [7:0] v, input logic [7:0] ea);
    u_mst.line_cond(1'h0);
    u_mst.xfer(v, 1'h1, q, a);
    chk(8'(a), ea);
  endtask : adr
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (2) @(posedge CLK);
    RESET_N <= 1'h1;
    axr(OFS_STAT);
    chk(q, ST_F8);
    axr(8'h10, RESP_SLV);
    axw(OFS_STAT, 8'h03);
    axr(OFS_STAT);
    chk(q, 8'hFB);
    own = 7'(rnd()) | 7'h10;
    axw(OFS_OWN, {own, 1'h0});
    axr(OFS_OWN);
    chk(q, {own, 1'h0});
    axw(OFS_OWN, 8'h00, RESP_OKAY, 4'h0);
    axr(OFS_OWN);
    chk(q, {own, 1'h0});
    chk(8'({SCL_OUT, SDA_OUT}), 8'h00);
    axw(OFS_CTRL, 8'h44);
    $display("register test done");
    adr({own, 1'h1}, 8'h00);
    sts(ST_A8);
    axr(OFS_CTRL);
    chk(q & 8'h80, 8'h80);
    chk(8'(SCL_OE_N), 8'h00);
    ld(8'hC4);
    rdb(1'h0);
    sts(ST_B8);
    ld(8'h84);
    rdb(1'h0);
    sts(ST_C8);
    tx_q.push_back(8'hFF);
    axw(OFS_CTRL, 8'hC4);
    rdb(1'h1);
    u_mst.line_cond(1'h1);
    sts(ST_F8);
    $display("transmit test done");
    ARB_LOST <= 1'h1;
    @(posedge CLK);
    ARB_LOST <= 1'h0;
    adr({own, 1'h1}, 8'h00);
    sts(ST_B0);
    ld(8'hC4);
    rdb(1'h1);
    sts(ST_C0);
    axw(OFS_CTRL, 8'hE4);
    repeat (20) @(posedge CLK);
    chk(8'(si_cnt), 8'h00);
    u_mst.line_cond(1'h1);
    for (int i = 0; i < 100 && si_cnt == 0; i++)
      @(posedge CLK);
    chk(8'(si_cnt), 8'h01);
    axw(OFS_CTRL, 8'h44);
    $display("arbitration test done");
    axw(OFS_OWN, {own, 1'h1});
    adr(8'h00, 8'h00);
    sts(ST_70);
    axw(OFS_CTRL, 8'hC4);
    d = rnd();
    u_mst.xfer(d, 1'h1, q, a);
    sts(ST_90);
    axr(OFS_DATA);
    chk(q, d);
    axw(OFS_CTRL, 8'h84);
    u_mst.xfer(rnd(), 1'h1, q, a);
    chk(8'(a), 8'h01);
    sts(ST_98);
    axw(OFS_CTRL, 8'hC4);
    u_mst.line_cond(1'h1);
    $display("general call test done");
    adr({own, 1'h0}, 8'h00);
    sts(ST_60);
    axw(OFS_CTRL, 8'hC4);
    u_mst.xfer(rnd(), 1'h1, q, a);
    sts(ST_80);
    axw(OFS_CTRL, 8'hC4);
    u_mst.line_cond(1'h1);
    sts(ST_A0);
    axw(OFS_CTRL, 8'hC4);
    $display("receive stop test done");
    axw(OFS_OWN, {own, 1'h0});
    axw(OFS_CTRL, 8'h04);
    adr({own, 1'h0}, 8'h01);
    u_mst.line_cond(1'h1);
    sts(ST_F8);
    axw(OFS_CTRL, 8'h44);
    adr(8'h00, 8'h01);
    u_mst.line_cond(1'h1);
    $display("isolation test done");
    SLEEP_IN <= 1'h1;
    adr({own, 1'h0}, 8'h00);
    repeat (8) @(posedge CLK);
    chk(8'(WAKE_REQ), 8'h01);
    SLEEP_IN <= 1'h0;
    sts(ST_60);
    chk(8'(SCL_OE_N), 8'h00);
    axw(OFS_CTRL, 8'hC4);
    repeat (8) @(posedge CLK);
    chk(8'(SCL_OE_N), 8'h01);
    u_mst.line_cond(1'h1);
    sts(ST_A0);
    axw(OFS_CTRL, 8'hC4);
    $display("sleep test done");
    conclude();
  end
endmodule : tb
